// File: rtl/ipsc_top.sv
// What this block does
// [RULE1] Start flag acts at next vsync rise
// [RULE2] Single-frame mode clears flag at area end
// [RULE3] Mode bit: 0 free run, 1 single frame
// [RULE4] Gate bit: 0 ignore gate, 1 qualify data
// [RULE5] Path 0: Bayer in, luma/chroma out
// [RULE6] Path 1: Bayer in, Bayer out
// [RULE7] Path 2: Bayer in, statistics only
// [RULE8] Path 3: 16-bit luma/chroma in and out
// [RULE9] Phase bits 7-6 odd/odd, reset 3
// [RULE10] Phase bits 5-4 odd/even, reset 2
// [RULE11] Phase bits 3-2 even/odd, reset 1
// [RULE12] Phase bits 1-0 even/even, reset 0
// [RULE13] Phase map ignored on path 3
// [RULE14] Reserved bits written zero, read zero
// [RULE15] Processing starts at vertical start line
// [RULE16] Area spans vertical size plus one lines
// [RULE17] Free run restarts every vsync rise
// [RULE18] Flag changes act only at vsync rise
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps

// =============================================================
// Synchronous FIFO with registered input ready
module ipsc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             rdy_q;
    wire              push = in_valid && rdy_q;
    wire              pop  = out_valid && out_ready;

    // Occupancy and next ready
    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];

    // Pointers and count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q  <= push ? wp_q + AW'(1) : wp_q;
            rp_q  <= pop ? rp_q + AW'(1) : rp_q;
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d < (AW+1)'(DEPTH));
        end
    end

    // Storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

endmodule : ipsc_fifo

// =============================================================
// Source control: registers, frame sequencer, data path select
module ipsc_top (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic [4:0]                    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic [31:0]                        avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic                          vertical_sync,
    input  wire logic                          line_start,
    input  wire logic                          pix_valid,
    input  wire logic                          pix_wgate,
    input  wire logic [ipsc_pkg::PIX_W-1:0]    pix_data,
    output logic                               pix_ready,
    output logic                               out_valid,
    input  wire logic                          out_ready,
    output ipsc_pkg::ipsc_pix_t                out_pix,
    output logic                               stat_valid,
    output ipsc_pkg::ipsc_pix_t                stat_pix,
    output logic                               frame_active
);
    // =========================================================
    // Reset release
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // =========================================================
    // Register bus slave
    logic                            wait_q;
    logic [31:0]                     rdata_q;
    logic                            start_q;
    logic                            single_q;
    logic                            wgate_q;
    ipsc_pkg::ipsc_path_t            path_q;
    logic [ipsc_pkg::PHASE_W-1:0]    phase_q;
    logic [ipsc_pkg::VSTART_W-1:0]   vstart_q;
    logic [ipsc_pkg::VSIZE_W-1:0]    vsize_q;
    ipsc_pkg::ipsc_state_t           st_q;
    ipsc_pkg::ipsc_state_t           st_d;
    logic [ipsc_pkg::LINE_W-1:0]     line_q;

    // Byte-lane merge of write data over current contents
    function automatic logic [31:0] lane_mix(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : lane_mix

    // Access strobes and decode
    wire        wr_go   = avs_write && !wait_q;
    wire        sel_st  = (avs_address == ipsc_pkg::OFS_START);
    wire        sel_md  = (avs_address == ipsc_pkg::OFS_MODE);
    wire        sel_pa  = (avs_address == ipsc_pkg::OFS_PATH);
    wire        sel_ph  = (avs_address == ipsc_pkg::OFS_PHASE);
    wire        sel_vs  = (avs_address == ipsc_pkg::OFS_VSTART);
    wire        sel_vz  = (avs_address == ipsc_pkg::OFS_VSIZE);
    wire        sel_sa  = (avs_address == ipsc_pkg::OFS_STATUS);
    // [RULE14] Reserved bits read zero
    wire [31:0] rv_st   = {31'h0, start_q};
    wire [31:0] rv_md   = {30'h0, wgate_q, single_q};
    wire [31:0] rv_pa   = {30'h0, path_q};
    wire [31:0] rv_ph   = {24'h0, phase_q};
    wire [31:0] rv_vs   = {16'h0, vstart_q};
    wire [31:0] rv_vz   = {19'h0, vsize_q};
    wire [31:0] rv_sa   = {13'h0, line_q, st_q};
    wire [31:0] rd_mux  = ({32{sel_st}} & rv_st) | ({32{sel_md}} & rv_md)
                        | ({32{sel_pa}} & rv_pa) | ({32{sel_ph}} & rv_ph)
                        | ({32{sel_vs}} & rv_vs) | ({32{sel_vz}} & rv_vz)
                        | ({32{sel_sa}} & rv_sa);
    wire [31:0] wv_st   = lane_mix(rv_st, avs_writedata, avs_byteenable);
    wire [31:0] wv_md   = lane_mix(rv_md, avs_writedata, avs_byteenable);
    wire [31:0] wv_pa   = lane_mix(rv_pa, avs_writedata, avs_byteenable);
    wire [31:0] wv_ph   = lane_mix(rv_ph, avs_writedata, avs_byteenable);
    wire [31:0] wv_vs   = lane_mix(rv_vs, avs_writedata, avs_byteenable);
    wire [31:0] wv_vz   = lane_mix(rv_vz, avs_writedata, avs_byteenable);

    // One wait cycle per access; read data captured with it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= !((avs_read || avs_write) && wait_q);
            rdata_q <= (avs_read && wait_q) ? rd_mux : rdata_q;
        end
    end
    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    // =========================================================
    // Frame sequencer
    logic vs_q;
    wire  vs_rise   = vertical_sync && !vs_q;
    wire  [ipsc_pkg::LINE_W-1:0] span_end = ipsc_pkg::LINE_W'(vstart_q)
                                          + ipsc_pkg::LINE_W'(vsize_q);
    // [RULE16] Last line is start plus size
    wire  frame_end = (st_q == ipsc_pkg::IPSC_ACTIVE) && line_start
                      && (line_q == span_end);
    // [RULE15] Area opens at start line
    wire  at_vstart = (line_q == ipsc_pkg::LINE_W'(vstart_q));

    // [RULE1] Flag sampled at vsync rise
    // [RULE18] Mid-frame changes wait here
    // [RULE17] Every rise restarts when enabled
    always_comb begin
        st_d = st_q;
        if (vs_rise) begin
            st_d = start_q ? ipsc_pkg::IPSC_SKIP : ipsc_pkg::IPSC_IDLE;
        end else begin
            unique case (st_q)
                ipsc_pkg::IPSC_IDLE:   st_d = ipsc_pkg::IPSC_IDLE;
                ipsc_pkg::IPSC_SKIP:   st_d = at_vstart ? ipsc_pkg::IPSC_ACTIVE
                                                        : ipsc_pkg::IPSC_SKIP;
                ipsc_pkg::IPSC_ACTIVE: st_d = frame_end ? ipsc_pkg::IPSC_IDLE
                                                        : ipsc_pkg::IPSC_ACTIVE;
                default:               st_d = ipsc_pkg::IPSC_IDLE;
            endcase
        end
    end

    // Lines counted from the vsync rise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vs_q   <= 1'b0;
            st_q   <= ipsc_pkg::IPSC_IDLE;
            line_q <= '0;
        end else begin
            vs_q   <= vertical_sync;
            st_q   <= st_d;
            line_q <= vs_rise ? '0 : (line_start ? line_q + 17'h00001 : line_q);
        end
    end

    // [RULE2] Single frame drops flag at end
    // [RULE3] Free run keeps it; software write wins
    wire start_d = (wr_go && sel_st) ? wv_st[ipsc_pkg::POS_START_EN]
                 : ((frame_end && single_q) ? 1'b0 : start_q);

    // [RULE9] Phase map resets to 3,2,1,0
    // [RULE10] Odd line even pixel resets 2
    // [RULE11] Even line odd pixel resets 1
    // [RULE12] Even line even pixel resets 0
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_q  <= ipsc_pkg::RST_START;
            single_q <= ipsc_pkg::RST_SINGLE;
            wgate_q  <= ipsc_pkg::RST_WGATE;
            path_q   <= ipsc_pkg::ipsc_path_t'(ipsc_pkg::RST_PATH);
            phase_q  <= ipsc_pkg::RST_PHASE;
            vstart_q <= ipsc_pkg::RST_VSTART;
            vsize_q  <= ipsc_pkg::RST_VSIZE;
        end else begin
            start_q  <= start_d;
            single_q <= (wr_go && sel_md) ? wv_md[ipsc_pkg::POS_MODE_SINGLE] : single_q;
            wgate_q  <= (wr_go && sel_md) ? wv_md[ipsc_pkg::POS_MODE_WGATE] : wgate_q;
            path_q   <= (wr_go && sel_pa) ? ipsc_pkg::ipsc_path_t'(wv_pa[1:0]) : path_q;
            phase_q  <= (wr_go && sel_ph) ? wv_ph[7:0] : phase_q;
            vstart_q <= (wr_go && sel_vs) ? wv_vs[15:0] : vstart_q;
            vsize_q  <= (wr_go && sel_vz) ? wv_vz[12:0] : vsize_q;
        end
    end

    // =========================================================
    // Pixel path
    logic col_q;
    logic fifo_rdy;
    logic fifo_ov;
    ipsc_pkg::ipsc_pix_t fifo_od;
    logic ov_q;
    ipsc_pkg::ipsc_pix_t opix_q;
    logic sv_q;
    ipsc_pkg::ipsc_pix_t spix_q;

    // [RULE4] Gate input used only when selected
    wire gate_ok  = !wgate_q || pix_wgate;
    wire take     = pix_valid && fifo_rdy && gate_ok && (st_q == ipsc_pkg::IPSC_ACTIVE);
    wire row_odd  = line_q[0] ^ vstart_q[0];
    wire [1:0] ph_sel = {row_odd, col_q};
    wire [1:0] ph_col = phase_q[2*ph_sel +: 2];
    // [RULE13] Phase map only for Bayer input
    wire is_yuv   = (path_q == ipsc_pkg::IPSC_PATH_YUV_YUV);
    wire [1:0] tag_col = is_yuv ? 2'h0 : ph_col;
    // [RULE5] Path 0 and [RULE6] path 1 feed the output
    // [RULE7] Path 2 keeps the output quiet
    // [RULE8] Path 3 passes luma/chroma straight
    wire push     = take && (path_q != ipsc_pkg::IPSC_PATH_STATS);
    wire stat_go  = take && !is_yuv;
    wire ipsc_pkg::ipsc_pix_t in_pix = '{path: path_q, color: tag_col, data: pix_data};
    wire o_adv    = !ov_q || out_ready;

    ipsc_fifo #(
        .WIDTH ($bits(ipsc_pkg::ipsc_pix_t)),
        .DEPTH (ipsc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_rdy),
        .in_data   (in_pix),
        .out_valid (fifo_ov),
        .out_ready (o_adv),
        .out_data  (fifo_od)
    );

    // Column parity, output stage and statistics tap
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            col_q  <= 1'b0;
            ov_q   <= 1'b0;
            opix_q <= '0;
            sv_q   <= 1'b0;
            spix_q <= '0;
        end else begin
            col_q  <= line_start ? 1'b0 : (take ? !col_q : col_q);
            ov_q   <= o_adv ? fifo_ov : ov_q;
            opix_q <= (o_adv && fifo_ov) ? fifo_od : opix_q;
            sv_q   <= stat_go;
            spix_q <= stat_go ? in_pix : spix_q;
        end
    end

    // Frame activity flag
    logic act_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= 1'b0;
        end else begin
            act_q <= (st_d == ipsc_pkg::IPSC_ACTIVE);
        end
    end

    assign pix_ready    = fifo_rdy;
    assign out_valid    = ov_q;
    assign out_pix      = opix_q;
    assign stat_valid   = sv_q;
    assign stat_pix     = spix_q;
    assign frame_active = act_q;

    // =========================================================
    // Checks
    sequence s_req;
        (avs_read || avs_write) && wait_q;
    endsequence
    sequence s_ans;
        !wait_q ##1 wait_q;
    endsequence

    a_bus_one_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        s_req |=> s_ans) else $error("bus answer not after one wait cycle");
    a_start_on_vsync: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
        (vs_rise && start_q) |=> (st_q == ipsc_pkg::IPSC_SKIP))
        else $error("enabled vsync rise did not start frame");
    a_no_early_start: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE18]
        (st_q == ipsc_pkg::IPSC_IDLE && !vs_rise) |=> (st_q == ipsc_pkg::IPSC_IDLE))
        else $error("frame started without vsync rise");
    a_single_clears: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
        (frame_end && single_q && !(wr_go && sel_st)) |=> !start_q)
        else $error("single frame did not clear start flag");
    a_free_run_keeps: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE17]
        (frame_end && !single_q && start_q && !(wr_go && sel_st)) |=> start_q)
        else $error("free run lost start flag");
    a_gate_blocks: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
        (wgate_q && !pix_wgate) |-> !take) else $error("gated pixel was taken");
    a_stats_no_out: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
        (path_q == ipsc_pkg::IPSC_PATH_STATS) |-> !push)
        else $error("output written on statistics path");
    a_yuv_no_stats: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
        (take && is_yuv) |=> !sv_q) else $error("statistics ran on luma/chroma input");
    a_yuv_color_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
        (push && is_yuv) |-> (in_pix.color == 2'h0)) else $error("phase used on path 3");
    a_area_start: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
        $rose(st_q == ipsc_pkg::IPSC_ACTIVE) |-> $past(at_vstart))
        else $error("area opened off start line");
    a_area_end: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE16]
        (frame_end && !vs_rise) |=> (st_q == ipsc_pkg::IPSC_IDLE && !act_q))
        else $error("area did not close after last line");

endmodule : ipsc_top

// File: rtl/ipsc_pkg.sv
// =============================================================
// Shared constants and types of the image pipe source control
package ipsc_pkg;

    // =========================================================
    // Register byte offsets
    localparam logic [4:0] OFS_START  = 5'h00;
    localparam logic [4:0] OFS_MODE   = 5'h04;
    localparam logic [4:0] OFS_PATH   = 5'h08;
    localparam logic [4:0] OFS_PHASE  = 5'h0c;
    localparam logic [4:0] OFS_VSTART = 5'h10;
    localparam logic [4:0] OFS_VSIZE  = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;

    // =========================================================
    // Field positions and widths
    localparam int POS_START_EN    = 0;
    localparam int POS_MODE_SINGLE = 0;
    localparam int POS_MODE_WGATE  = 1;
    localparam int PATH_W          = 2;
    localparam int PHASE_W         = 8;
    localparam int VSTART_W        = 16;
    localparam int VSIZE_W         = 13;
    localparam int LINE_W          = 17;
    localparam int PIX_W           = 16;

    // =========================================================
    // Reset values
    localparam logic                RST_START  = 1'b0;
    localparam logic                RST_SINGLE = 1'b0;
    localparam logic                RST_WGATE  = 1'b0;
    localparam logic [PATH_W-1:0]   RST_PATH   = 2'h0;
    localparam logic [PHASE_W-1:0]  RST_PHASE  = 8'he4;
    localparam logic [VSTART_W-1:0] RST_VSTART = 16'h0000;
    localparam logic [VSIZE_W-1:0]  RST_VSIZE  = 13'h0000;

    // =========================================================
    // Buffer shape
    localparam int FIFO_DEPTH = 16;

    // Data path selections
    typedef enum logic [1:0] {
        IPSC_PATH_BAYER_YUV = 2'h0,
        IPSC_PATH_BAYER_RAW = 2'h1,
        IPSC_PATH_STATS     = 2'h2,
        IPSC_PATH_YUV_YUV   = 2'h3
    } ipsc_path_t;

    // Frame sequencer states
    typedef enum logic [1:0] {
        IPSC_IDLE,
        IPSC_SKIP,
        IPSC_ACTIVE
    } ipsc_state_t;

    // One pixel on its way downstream
    typedef struct packed {
        ipsc_path_t        path;
        logic [1:0]        color;
        logic [PIX_W-1:0]  data;
    } ipsc_pix_t;

endpackage : ipsc_pkg

// File: tb/ipsc_src_model.sv
`timescale 1ns/100ps

// =============================================================
// Upstream source: frame sync, line pulses, pixels with gate
module ipsc_src_model (
    input  wire logic  mclk,
    input  wire logic  pix_ready,
    output logic       vertical_sync,
    output logic       line_start,
    output logic       pix_valid,
    output logic       pix_wgate,
    output logic [15:0] pix_data
);
    int gate_ok;

    // Quiet lines at time zero
    initial begin
        vertical_sync = 1'b0;
        line_start    = 1'b0;
        pix_valid     = 1'b0;
        pix_wgate     = 1'b0;
        pix_data      = 16'h5a5a;
    end

    // Idle cycles: data and gate keep moving so stale values never match
    task automatic idle(input int n);
        repeat (n) begin
            pix_valid  <= 1'b0;
            line_start <= 1'b0;
            pix_data   <= ~pix_data;
            pix_wgate  <= ~pix_wgate;
            @(posedge mclk);
        end
    endtask : idle

    // One frame; pixels hold until pix_ready is high, gate counted inside lo..hi
    task automatic frame(input int lines, input int ppl, input int lo, input int hi,
                         input bit grand);
        gate_ok = 0;
        idle(3);
        vertical_sync <= 1'b1;
        idle(2);
        for (int j = 1; j <= lines; j++) begin
            line_start <= 1'b1;
            @(posedge mclk);
            idle(3);
            for (int k = 0; k < ppl; k++) begin
                pix_valid <= 1'b1;
                pix_data  <= {j[7:0], k[7:0]};
                pix_wgate <= grand ? 1'($urandom) : 1'b1;
                do @(posedge mclk); while (pix_ready !== 1'b1);
                if (pix_wgate && j >= lo && j <= hi) gate_ok++;
            end
            idle(2);
            vertical_sync <= 1'b0;
        end
        idle(2);
    endtask : frame
endmodule : ipsc_src_model

// File: tb/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, s); end end

// =============================================================
// Bench: registers, frames on every path, buffer stall, gating
module testbench;
    logic                mclk, resetn, avs_read, avs_write, stall, chk;
    logic [4:0]          avs_address;
    logic [31:0]         avs_writedata, avs_readdata, rd;
    logic                avs_waitrequest, pix_ready, out_valid, out_ready;
    logic                vertical_sync, line_start, pix_valid, pix_wgate;
    logic                stat_valid, frame_active;
    logic [15:0]         pix_data;
    logic [1:0]          path;
    logic [7:0]          phase;
    ipsc_pkg::ipsc_pix_t out_pix, stat_pix;
    int                  fails, tests_run, n_stat, n_out, nf, ppl, vst, vsz, i;
    int                  ofs [6] = '{0, 4, 8, 12, 16, 20};
    int                  msk [6] = '{1, 3, 3, 255, 65535, 8191};
    int                  rst [6] = '{0, 0, 0, 228, 0, 0};

    ipsc_top DUT (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .vertical_sync(vertical_sync),
        .line_start(line_start), .pix_valid(pix_valid), .pix_wgate(pix_wgate),
        .pix_data(pix_data), .pix_ready(pix_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_pix(out_pix), .stat_valid(stat_valid),
        .stat_pix(stat_pix), .frame_active(frame_active));

    ipsc_src_model src (.mclk(mclk), .pix_ready(pix_ready), .vertical_sync(vertical_sync),
        .line_start(line_start), .pix_valid(pix_valid), .pix_wgate(pix_wgate),
        .pix_data(pix_data));

    // Expected colour: phase field picked by line and pixel parity
    function automatic logic [1:0] exp_col(input int n);
        int l;
        l = (n % nf) / ppl;
        if (path == 2'h3) return 2'h0;
        return phase[2 * (2 * (l % 2) + (n % ppl) % 2) +: 2];
    endfunction : exp_col

    // Expected data: source tags each pixel with line and column
    function automatic logic [15:0] exp_dat(input int n);
        int l, p;
        l = (n % nf) / ppl + vst;
        p = n % ppl;
        return {l[7:0], p[7:0]};
    endfunction : exp_dat

    // Clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Random stalls downstream, full stall on request
    always @(posedge mclk) out_ready <= !stall && ($urandom % 4 != 0);

    // Check every pixel leaving the block while chk is set
    always @(posedge mclk) begin
        if (stat_valid === 1'b1) begin
            if (chk) `CHK("stat color", exp_col(n_stat), stat_pix.color)
            if (chk) `CHK("stat data", exp_dat(n_stat), stat_pix.data)
            n_stat++;
        end
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            if (chk) `CHK("out data", exp_dat(n_out), out_pix.data)
            if (chk) `CHK("out color", exp_col(n_out), out_pix.color)
            `CHK("out path", path, out_pix.path)
            n_out++;
        end
    end

    // One register access; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("register read", e, rd)
    endtask : rchk

    // One frame from the source, then drain the buffer
    task automatic run(input bit grand);
        n_stat = 0;
        n_out  = 0;
        src.frame(vst + vsz + 1, ppl, vst, vst + vsz, grand);
        repeat (4) @(posedge mclk);
        for (i = 0; i < 400 && out_valid === 1'b1; i++) @(posedge mclk);
    endtask : run

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    // Watchdog
    initial begin
        #80000;
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, stall, chk} = '0;
        {fails, tests_run, n_stat, n_out, path, phase} = '0;
        out_ready = 1'b0;
        resetn = 1'b0;
        void'($urandom(32'h1405bcb0));
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk(ipsc_pkg::OFS_PHASE, 32'he4);
        `CHK("odd odd", 2'h3, rd[7:6])
        `CHK("odd even", 2'h2, rd[5:4])
        `CHK("even odd", 2'h1, rd[3:2])
        `CHK("even even", 2'h0, rd[1:0])
        for (int r = 0; r < 6; r++) begin
            rchk(5'(ofs[r]), rst[r]);
            // Software keeps reserved bits at zero
            bus(1'b1, 5'(ofs[r]), 32'(msk[r]));
            rchk(5'(ofs[r]), msk[r]);
            bus(1'b1, 5'(ofs[r]), 32'h0);
        end
        bus(1'b1, 5'h1c, 32'hffffffff);
        rchk(5'h1c, 32'h0);
        rchk(ipsc_pkg::OFS_STATUS, 32'h0);
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            path = 2'(p);
            phase = 8'($urandom);
            vst = 1 + $urandom % 3;
            vsz = $urandom % 3;
            ppl = 2 + $urandom % 5;
            nf = (vsz + 1) * ppl;
            chk = 1'b1;
            bus(1'b1, ipsc_pkg::OFS_PATH, 32'(path));
            bus(1'b1, ipsc_pkg::OFS_PHASE, 32'(phase));
            bus(1'b1, ipsc_pkg::OFS_VSTART, 32'(vst));
            bus(1'b1, ipsc_pkg::OFS_VSIZE, 32'(vsz));
            bus(1'b1, ipsc_pkg::OFS_MODE, 32'h1);
            bus(1'b1, ipsc_pkg::OFS_START, 32'h1);
            repeat (8) @(posedge mclk);
            `CHK("wait for sync", 1'b0, frame_active)
            run(1'b0);
            `CHK("stat count", (p == 3) ? 0 : nf, n_stat)
            `CHK("out count", (p == 2) ? 0 : nf, n_out)
            `CHK("area closed", 1'b0, frame_active)
            rchk(ipsc_pkg::OFS_START, 32'h0);
            $display("test path %0d done", p);
        end
        path = 2'h0;
        bus(1'b1, ipsc_pkg::OFS_PATH, 32'h0);
        ppl = 12;
        vsz = 1;
        nf = 24;
        bus(1'b1, ipsc_pkg::OFS_VSIZE, 32'(vsz));
        bus(1'b1, ipsc_pkg::OFS_MODE, 32'h0);
        bus(1'b1, ipsc_pkg::OFS_START, 32'h1);
        stall <= 1'b1;
        fork
            run(1'b0);
            begin
                for (int k = 0; k < 3000 && pix_ready !== 1'b0; k++) @(posedge mclk);
                `CHK("buffer full", 1'b0, pix_ready)
                `CHK("stalled out", 0, n_out)
                stall <= 1'b0;
            end
        join
        `CHK("drained", nf, n_out)
        rchk(ipsc_pkg::OFS_START, 32'h1);
        $display("test buffer done");
        fork
            run(1'b0);
            begin
                for (int k = 0; k < 500 && frame_active !== 1'b1; k++) @(posedge mclk);
                bus(1'b1, ipsc_pkg::OFS_START, 32'h0);
            end
        join
        `CHK("whole frame", nf, n_stat)
        run(1'b0);
        `CHK("stopped", 0, n_stat)
        $display("test free run done");
        chk = 1'b0;
        for (int g = 0; g < 2; g++) begin
            bus(1'b1, ipsc_pkg::OFS_MODE, 32'(2 * g + 1));
            bus(1'b1, ipsc_pkg::OFS_START, 32'h1);
            run(1'b1);
            `CHK("gated count", g ? src.gate_ok : nf, n_stat)
        end
        $display("test gate done");
        close_out();
    end
endmodule : testbench
